/* File: pkg/pwb_pkg.sv */
package pwb_pkg;

    // clock rates, periods in picoseconds
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int PCI_PERIOD_PS  = 30000;
    localparam int CORE_PERIOD_PS = 62500;
    localparam int PCI_DIV        = PCI_PERIOD_PS / CLK_PERIOD_PS;
    localparam int CORE_DIV       = CORE_PERIOD_PS / CLK_PERIOD_PS;

    // bus commands, as seen on the command lines
    localparam logic [3:0] CMD_MEM_RD     = 4'h6;
    localparam logic [3:0] CMD_MEM_WR     = 4'h7;
    localparam logic [3:0] CMD_MEM_RD_MUL = 4'hc;
    localparam logic [3:0] CMD_MEM_RD_LN  = 4'he;
    localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

    // second window decode
    localparam logic [3:0] CREG_PAGE     = 4'h0;
    localparam logic [6:0] IFREG_PAGE    = 7'h40;
    localparam int         IFREG_NUM     = 8;
    localparam int         FIFO_NE_BIT   = 30;
    localparam int         ENH_ACCESS_BIT = 14;

    // write fifo
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW    = 4;

    // delayed read timing, in bus and core clocks
    localparam logic [7:0] PCI_WAIT_SGL  = 8'h08;
    localparam logic [7:0] PCI_WAIT_DBL  = 8'h0d;
    localparam logic [7:0] CORE_WORD0    = 8'h05;
    localparam logic [7:0] CORE_WORD1    = 8'h06;
    localparam logic [6:0] CONT_ENH_SGL  = 7'h03;
    localparam logic [6:0] CONT_ENH_DBL  = 7'h06;
    localparam logic [6:0] CONT_SLOW_SGL = 7'h43;
    localparam logic [6:0] CONT_SLOW_DBL = 7'h4a;

    typedef enum logic [1:0] {
        RSP_DONE   = 2'h0,
        RSP_DATA   = 2'h1,
        RSP_RETRY  = 2'h2,
        RSP_ABORT  = 2'h3
    } pwb_rsp_e;

    typedef enum logic [3:0] {
        RD_IDLE = 4'b0001,
        RD_PCI  = 4'b0010,
        RD_CORE = 4'b0100,
        RD_DONE = 4'b1000
    } pwb_rd_e;

    typedef struct packed {
        logic [3:0]  cmd;
        logic        bar1;
        logic [17:0] addr;
        logic [3:0]  be_n;
        logic [31:0] data;
    } pwb_req_s;

    typedef struct packed {
        logic        is_reg;
        logic [15:0] base;
        logic [3:0]  be;
        logic [31:0] data;
    } pwb_wf_s;

    typedef struct packed {
        logic        is_reg;
        logic [15:0] addr;
        logic [15:0] data;
    } pwb_cw_s;

endpackage

/* File: src/pwb_skid.sv */
module pwb_skid
    import pwb_pkg::*;
#(
    parameter int W = 33
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    logic [W-1:0] mem_ff [2];
    logic         wp_ff;
    logic         rp_ff;
    logic [1:0]   cnt_ff;
    logic         push;
    logic         pop;

    // two entries let the receiver stall for a cycle without losing a word
    assign in_ready_o  = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o  = mem_ff[rp_ff];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) wp_ff <= ~wp_ff;
            if (pop)  rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule // pwb_skid

/* File: src/pwb_bridge.sv */
// How it works
// RULE1 - single read: 8-10 bus plus 5-6 core clocks
// RULE2 - double read: 13-16 bus plus 11-14 core clocks
// RULE3 - fast access: contention adds up to 3/6 core clocks
// RULE4 - slow access: contention adds up to 67/74 core clocks
// RULE5 - fast access is core config six bit 14
// RULE6 - core memory and register 00h-FCh writes go to the fifo
// RULE7 - interface register 800h-81Ch writes land directly
// RULE8 - lone-byte core memory write ends in target abort
// RULE9 - lone-byte core register write ends in target abort
// RULE10 - core registers take only the lower word of a write
// RULE11 - write and invalidate acts as memory write
// RULE12 - 16-dword burst taken unstalled while the fifo has room
// RULE13 - read queued only if fifo empty and none pending, else retry
// RULE14 - repeated read retried until data ready, then completes
// RULE15 - register 800h bit 30 is fifo-not-empty
// RULE16 - fifo drains in order as 16-bit writes, empty halves skipped
module pwb_bridge
    import pwb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire pwb_req_s    req_i,
    output logic             rsp_valid_o,
    output pwb_rsp_e         rsp_code_o,
    output logic [31:0]      rsp_data_o,
    output logic             core_wr_valid_o,
    input  wire logic        core_wr_ready_i,
    output pwb_cw_s          core_wr_o,
    output logic             core_rd_o,
    output logic             core_rd_reg_o,
    output logic [15:0]      core_rd_addr_o,
    input  wire logic [15:0] core_rdata_i,
    input  wire logic        core_busy_i,
    input  wire logic [15:0] core_cfg6_i
);

    ////////////////////////////////////////
    // request decode
    logic [3:0] be;
    logic       is_rd;
    logic       is_wr;
    logic       tgt_mem;
    logic       tgt_reg;
    logic       tgt_if;
    logic       one_byte;
    logic       to_core;
    logic       rd_zero;
    logic       rd_dbl;
    logic       fifo_full;
    logic       fifo_empty;
    logic       take;
    logic       push;

    assign be       = ~req_i.be_n;
    assign is_rd    = (req_i.cmd == CMD_MEM_RD) || (req_i.cmd == CMD_MEM_RD_MUL)
                      || (req_i.cmd == CMD_MEM_RD_LN);
    assign is_wr    = (req_i.cmd == CMD_MEM_WR) || (req_i.cmd == CMD_MEM_WR_INV); // RULE11
    assign tgt_mem  = !req_i.bar1;
    assign tgt_reg  = req_i.bar1 && (req_i.addr[11:8] == CREG_PAGE);
    assign tgt_if   = req_i.bar1 && (req_i.addr[11:5] == IFREG_PAGE);
    assign one_byte = (be[0] ^ be[1]) | (be[2] ^ be[3]);
    assign to_core  = tgt_mem | tgt_reg;
    // no lanes, or register upper half only: zeros at once
    assign rd_zero  = (be == 4'h0) || (tgt_reg && (be[1:0] == 2'h0));
    assign rd_dbl   = tgt_mem && (be[1:0] != 2'h0) && (be[3:2] != 2'h0);
    assign push     = take && is_wr && to_core && !one_byte; // RULE6

    // only a core write into a full fifo waits; a 16-dword burst fits whole
    assign req_ready_o = !(is_wr && to_core && !one_byte && fifo_full); // RULE12
    assign take        = req_valid_i & req_ready_o;

    ////////////////////////////////////////
    // clock enables for the bus and core rates
    logic [3:0] pdiv_ff;
    logic [3:0] cdiv_ff;
    logic       pci_ce;
    logic       core_ce;

    assign pci_ce  = (pdiv_ff == 4'(PCI_DIV - 1));
    assign core_ce = (cdiv_ff == 4'(CORE_DIV - 1));

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pdiv_ff <= 4'h0;
            cdiv_ff <= 4'h0;
        end else begin
            pdiv_ff <= pci_ce ? 4'h0 : pdiv_ff + 4'h1;
            cdiv_ff <= core_ce ? 4'h0 : cdiv_ff + 4'h1;
        end
    end

    ////////////////////////////////////////
    // interface registers, written straight from the bus
    logic [31:0] ifreg_ff [IFREG_NUM];
    logic [31:0] if_rdata;

    genvar gi;
    generate
        for (gi = 0; gi < IFREG_NUM; gi++) begin : g_ifreg
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    ifreg_ff[gi] <= 32'h0;
                end else if (take && is_wr && tgt_if && (req_i.addr[4:2] == 3'(gi))) begin
                    for (int b = 0; b < 4; b++) begin
                        if (be[b]) ifreg_ff[gi][8*b +: 8] <= req_i.data[8*b +: 8]; // RULE7
                    end
                end
            end
        end
    endgenerate

    // status flag overlays the stored bit so software polls without a retry
    always_comb begin
        if_rdata = ifreg_ff[req_i.addr[4:2]];
        if (req_i.addr[4:2] == 3'h0) begin
            if_rdata[FIFO_NE_BIT] = !fifo_empty; // RULE15
        end
    end

    ////////////////////////////////////////
    // posted write fifo
    pwb_wf_s          wf_mem_ff [FIFO_DEPTH];
    logic [FIFO_AW:0] wp_ff;
    logic [FIFO_AW:0] rp_ff;
    pwb_wf_s          head;
    pwb_wf_s          new_ent;
    logic             half_ff;
    logic             lo_en;
    logic             hi_en;
    logic             half_sel;
    logic             sk_in_valid;
    logic             sk_in_ready;
    logic             entry_done;
    pwb_cw_s          sk_in;
    logic             sk_out_valid;
    logic             rd_core;

    assign fifo_empty = (wp_ff == rp_ff);
    assign fifo_full  = (wp_ff[FIFO_AW] != rp_ff[FIFO_AW])
                        && (wp_ff[FIFO_AW-1:0] == rp_ff[FIFO_AW-1:0]);
    assign head       = wf_mem_ff[rp_ff[FIFO_AW-1:0]];

    always_comb begin
        new_ent.is_reg = tgt_reg;
        new_ent.base   = tgt_reg ? {10'h0, req_i.addr[7:2]} : {req_i.addr[16:2], 1'b0};
        new_ent.be     = be;
        new_ent.data   = req_i.data;
    end

    // registers hold only the lower word; upper half dropped
    assign lo_en       = (head.be[1:0] != 2'h0);
    assign hi_en       = !head.is_reg && (head.be[3:2] != 2'h0); // RULE10
    assign half_sel    = half_ff | !lo_en;
    assign sk_in_valid = !fifo_empty && (half_sel ? hi_en : 1'b1); // RULE16
    assign entry_done  = !fifo_empty && (half_sel ? (!hi_en || sk_in_ready)
                                                  : (sk_in_ready && !hi_en));

    always_comb begin
        sk_in.is_reg = head.is_reg;
        sk_in.addr   = head.base | {15'h0, half_sel};
        sk_in.data   = half_sel ? head.data[31:16] : head.data[15:0];
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            wf_mem_ff[wp_ff[FIFO_AW-1:0]] <= new_ent;
        end
    end

    // pointers and the half being drained, oldest entry first
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_ff   <= '0;
            rp_ff   <= '0;
            half_ff <= 1'b0;
        end else begin
            if (push) wp_ff <= wp_ff + 5'h1;
            if (entry_done) begin
                rp_ff   <= rp_ff + 5'h1; // RULE16
                half_ff <= 1'b0;
            end else if (!half_sel && sk_in_valid && sk_in_ready) begin
                half_ff <= 1'b1;
            end
        end
    end

    // core writes hold off while a delayed read owns the core port
    pwb_skid #(.W($bits(pwb_cw_s))) u_skid (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (sk_in_valid),
        .in_ready_o  (sk_in_ready),
        .in_data_i   (sk_in),
        .out_valid_o (sk_out_valid),
        .out_ready_i (core_wr_ready_i && !rd_core),
        .out_data_o  (core_wr_o)
    );
    assign core_wr_valid_o = sk_out_valid && !rd_core;

    ////////////////////////////////////////
    // delayed read sequencer
    pwb_rd_e     st_ff;
    logic        p_bar1_ff;
    logic [17:0] p_addr_ff;
    logic [3:0]  p_be_n_ff;
    logic        p_dbl_ff;
    logic        p_reg_ff;
    logic        word_ff;
    logic [7:0]  cnt_ff;
    logic [6:0]  ext_ff;
    logic [31:0] rd_data_ff;
    logic [15:0] rd_addr_ff;
    logic        match;
    logic        enq;
    logic        hit;
    logic        stall;
    logic        wsel;
    logic [6:0]  cont_max;
    logic [7:0]  core_tgt;

    assign match = (st_ff != RD_IDLE) && (p_bar1_ff == req_i.bar1)
                   && (p_addr_ff == req_i.addr) && (p_be_n_ff == req_i.be_n);
    assign hit   = take && is_rd && to_core && match && (st_ff == RD_DONE); // RULE14
    assign enq   = take && is_rd && to_core && !(tgt_reg && one_byte) && !rd_zero
                   && (st_ff == RD_IDLE) && fifo_empty; // RULE13
    assign rd_core = (st_ff == RD_CORE);

    // contention allowance follows the core's access mode
    assign cont_max = core_cfg6_i[ENH_ACCESS_BIT] ? // RULE5
                      (p_dbl_ff ? CONT_ENH_DBL : CONT_ENH_SGL) : // RULE3
                      (p_dbl_ff ? CONT_SLOW_DBL : CONT_SLOW_SGL); // RULE4
    // past the allowance the read takes the ram anyway
    assign stall    = core_busy_i && (ext_ff < cont_max);
    assign core_tgt = (p_dbl_ff && word_ff) ? CORE_WORD1 : CORE_WORD0;
    assign wsel     = p_dbl_ff ? word_ff : (p_be_n_ff[1:0] == 2'h3);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_ff      <= RD_IDLE;
            p_bar1_ff  <= 1'b0;
            p_addr_ff  <= 18'h0;
            p_be_n_ff  <= 4'hf;
            p_dbl_ff   <= 1'b0;
            p_reg_ff   <= 1'b0;
            word_ff    <= 1'b0;
            cnt_ff     <= 8'h0;
            ext_ff     <= 7'h0;
            rd_data_ff <= 32'h0;
            rd_addr_ff <= 16'h0;
        end else begin
            case (st_ff)
                RD_IDLE: begin
                    if (enq) begin
                        st_ff      <= RD_PCI;
                        p_bar1_ff  <= req_i.bar1;
                        p_addr_ff  <= req_i.addr;
                        p_be_n_ff  <= req_i.be_n;
                        p_dbl_ff   <= rd_dbl;
                        p_reg_ff   <= tgt_reg;
                        word_ff    <= 1'b0;
                        cnt_ff     <= 8'h0;
                        ext_ff     <= 7'h0;
                        rd_data_ff <= 32'h0;
                    end
                end
                RD_PCI: begin
                    if (pci_ce) begin
                        cnt_ff <= cnt_ff + 8'h1;
                        if (cnt_ff == (p_dbl_ff ? PCI_WAIT_DBL : PCI_WAIT_SGL)) begin
                            st_ff      <= RD_CORE; // RULE1 RULE2
                            cnt_ff     <= 8'h0;
                            rd_addr_ff <= p_reg_ff ? {10'h0, p_addr_ff[7:2]}
                                        : {p_addr_ff[16:2], wsel};
                        end
                    end
                end
                RD_CORE: begin
                    if (core_ce && stall) begin
                        ext_ff <= ext_ff + 7'h1;
                    end else if (core_ce) begin
                        cnt_ff <= cnt_ff + 8'h1;
                        if (cnt_ff == core_tgt) begin
                            rd_data_ff[16*wsel +: 16] <= core_rdata_i;
                            cnt_ff <= 8'h0;
                            if (p_dbl_ff && !word_ff) begin
                                word_ff       <= 1'b1; // RULE2
                                rd_addr_ff[0] <= 1'b1;
                            end else begin
                                st_ff <= RD_DONE; // RULE1
                            end
                        end
                    end
                end
                RD_DONE: begin
                    if (hit) st_ff <= RD_IDLE;
                end
                default: st_ff <= RD_IDLE;
            endcase
        end
    end

    assign core_rd_o      = rd_core;
    assign core_rd_reg_o  = p_reg_ff;
    assign core_rd_addr_o = rd_addr_ff;

    ////////////////////////////////////////
    // answer to each taken read or write of core memory, core register or interface register, one cycle later
    logic        rsp_v_ff;
    pwb_rsp_e    rsp_c_ff;
    logic [31:0] rsp_d_ff;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_v_ff <= 1'b0;
            rsp_c_ff <= RSP_DONE;
            rsp_d_ff <= 32'h0;
        end else begin
            rsp_v_ff <= take && (is_rd || is_wr) && (to_core || tgt_if);
            if (take) begin
                rsp_d_ff <= 32'h0;
                if (tgt_if) begin
                    rsp_c_ff <= is_rd ? RSP_DATA : RSP_DONE; // RULE7
                    rsp_d_ff <= if_rdata;
                end else if (one_byte && (is_wr || tgt_reg)) begin
                    rsp_c_ff <= RSP_ABORT; // RULE8 RULE9
                end else if (is_wr) begin
                    rsp_c_ff <= RSP_DONE;
                end else if (rd_zero) begin
                    rsp_c_ff <= RSP_DATA;
                end else if (hit) begin
                    rsp_c_ff <= RSP_DATA; // RULE14
                    rsp_d_ff <= rd_data_ff;
                end else begin
                    rsp_c_ff <= RSP_RETRY; // RULE13
                end
            end
        end
    end

    assign rsp_valid_o = rsp_v_ff;
    assign rsp_code_o  = rsp_c_ff;
    assign rsp_data_o  = rsp_d_ff;

endmodule // pwb_bridge

/* File: tb/pwb_bridge_checker.sv */
module pwb_bridge_checker
    import pwb_pkg::*;
(
    input  wire logic     clk_i,
    input  wire logic     rst_b_i,
    input  wire logic     req_valid_i,
    input  wire logic     req_ready_o,
    input  wire pwb_req_s req_i,
    input  wire logic     rsp_valid_o,
    input  wire pwb_rsp_e rsp_code_o,
    input  wire logic     core_wr_valid_o,
    input  wire logic     core_wr_ready_i,
    input  wire pwb_cw_s  core_wr_o,
    input  wire logic     core_rd_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // decoded view of the request on the port
    logic        tk, wr, rd, creg, ifr, sb;
    logic [10:0] rd_cnt_ff;
    assign tk   = req_valid_i & req_ready_o;
    assign wr   = req_i.cmd == CMD_MEM_WR || req_i.cmd == CMD_MEM_WR_INV;
    assign rd   = req_i.cmd inside {CMD_MEM_RD, CMD_MEM_RD_MUL, CMD_MEM_RD_LN};
    assign creg = req_i.bar1 && req_i.addr[17:8] == 10'h000;
    assign ifr  = req_i.bar1 && req_i.addr[17:5] == {6'h00, IFREG_PAGE};
    assign sb   = ^req_i.be_n[1:0] | ^req_i.be_n[3:2]; // one byte alone in a half

    // length of a core read phase; saturates so a stuck read never wraps to legal
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_cnt_ff <= 11'h000;
        end else if (!core_rd_o) begin
            rd_cnt_ff <= 11'h000;
        end else if (rd_cnt_ff != 11'h7ff) begin
            rd_cnt_ff <= rd_cnt_ff + 11'h001;
        end
    end

    ////////////////////////////////////////
    chk_rsp_cause: assert property (rsp_valid_o |-> $past(tk))
        else $error("response without request");
    chk_take_answer: assert property (tk && (wr || rd) && (!req_i.bar1 || creg || ifr) |=> rsp_valid_o)
        else $error("no response");
    chk_mem_abort: assert property (tk && wr && !req_i.bar1 && sb |=> rsp_code_o == RSP_ABORT)
        else $error("memory byte write not aborted");
    chk_reg_abort: assert property (tk && wr && creg && sb |=> rsp_code_o == RSP_ABORT)
        else $error("register byte write not aborted");
    chk_wr_posted: assert property (tk && req_i.cmd == CMD_MEM_WR && !req_i.bar1 && !sb
        |=> rsp_code_o == RSP_DONE)
        else $error("memory write not posted");
    chk_mwi_alias: assert property (tk && req_i.cmd == CMD_MEM_WR_INV && !req_i.bar1 && !sb
        |=> rsp_valid_o && rsp_code_o == RSP_DONE)
        else $error("invalidate write not posted");
    chk_ifreg_direct: assert property (tk && rd && ifr |=> rsp_code_o == RSP_DATA)
        else $error("interface read delayed");
    chk_retry_pend: assert property (tk && rd && !req_i.bar1 && req_i.be_n != 4'hf && core_rd_o
        |=> rsp_code_o == RSP_RETRY)
        else $error("pending read not retried");
    chk_read_excl: assert property (core_rd_o |-> !core_wr_valid_o)
        else $error("drain while core read active");
    chk_drain_hold: assert property (core_wr_valid_o && !core_wr_ready_i
        |=> core_wr_valid_o && $stable(core_wr_o))
        else $error("stalled core write changed");
    chk_ready_low: assert property (req_valid_i && !req_ready_o |-> wr && (!req_i.bar1 || creg))
        else $error("non-write request stalled");
    chk_read_bound: assert property (core_rd_o |-> rd_cnt_ff < 11'h578)
        else $error("core read phase too long");
endmodule // pwb_bridge_checker

bind pwb_bridge pwb_bridge_checker u_chk (.*);

/* File: tb/pwb_core_model.sv */
module pwb_core_model
    import pwb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        stall_i,
    input  wire logic        wr_valid_i,
    output logic             wr_ready_o,
    input  wire pwb_cw_s     wr_i,
    input  wire logic        rd_i,
    input  wire logic        rd_reg_i,
    input  wire logic [15:0] rd_addr_i,
    output logic [15:0]      rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem_ff [256];
    logic [15:0] reg_ff [64];
    logic [15:0] last_ff;

    // the bench stalls the core to keep words queued in the bridge
    assign wr_ready_o = !stall_i;
    // read data only while the bridge owns the port; inverted junk otherwise
    assign rdata_o = !rd_i ? ~last_ff : rd_reg_i ? reg_ff[rd_addr_i[5:0]] : mem_ff[rd_addr_i[7:0]];

    // storage takes each accepted word as it arrives
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 256; i++) mem_ff[i] <= 16'h0000;
            for (int i = 0; i < 64; i++) reg_ff[i] <= 16'h0000;
            last_ff <= 16'h0000;
        end else begin
            if (wr_valid_i && wr_ready_o && wr_i.is_reg) reg_ff[wr_i.addr[5:0]] <= wr_i.data;
            if (wr_valid_i && wr_ready_o && !wr_i.is_reg) mem_ff[wr_i.addr[7:0]] <= wr_i.data;
            if (rd_i) last_ff <= rdata_o;
        end
    end
endmodule // pwb_core_model

/* File: tb/pwb_bridge_tb.sv */
module pwb_bridge_tb import pwb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, stall = 1'b0;
    logic        req_ready_o, rsp_valid_o, core_wr_valid_o, core_wr_ready_i;
    logic        core_rd_o, core_rd_reg_o, core_busy_i = 1'b0;
    pwb_req_s    req_i = '0;
    pwb_rsp_e    rsp_code_o, code;
    pwb_cw_s     core_wr_o;
    logic [31:0] rsp_data_o, rdat;
    logic [15:0] core_rd_addr_o, core_rdata_i, core_cfg6_i = 16'h0000;
    int          bad_count = 0, num_checks = 0, cyc = 0, t, n;
    localparam int P = PCI_DIV;
    localparam int C = CORE_DIV;

    // clock and a cycle count for latencies
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;

    pwb_bridge DUT (.*);
    pwb_core_model u_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .stall_i(stall),
        .wr_valid_i(core_wr_valid_o), .wr_ready_o(core_wr_ready_i), .wr_i(core_wr_o),
        .rd_i(core_rd_o), .rd_reg_i(core_rd_reg_o), .rd_addr_i(core_rd_addr_o),
        .rdata_o(core_rdata_i));

    ////////////////////////////////////////////////////////////
    task automatic chk(string w, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic win(string w, int v, int lo, int hi);
        num_checks++;
        if (v < lo - 2 || v > hi + 3) begin
            bad_count++;
            $display("Error %s expected %0d..%0d seen %0d", w, lo, hi, v);
        end
    endtask
    task automatic end_sim();
        if (bad_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one request, held until taken; answer seen a cycle later
    task automatic xfer(logic [3:0] c, logic b, logic [17:0] a, logic [3:0] be, logic [31:0] d);
        int k;
        req_i <= {c, b, a, be, d};
        req_valid_i <= 1'b1;
        #1;
        k = 0;
        while (req_ready_o !== 1'b1) begin
            @(posedge clk_i);
            #1;
            k++;
            if (k > 200) begin
                chk("req_ready_o", 1, req_ready_o);
                end_sim();
            end
        end
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        chk("rsp_valid_o", 1, rsp_valid_o);
        code = rsp_code_o;
        rdat = rsp_data_o;
    endtask
    // retried read; t is its latency in clocks
    task automatic rd_poll(logic [3:0] c, logic b, logic [17:0] a, logic [3:0] be);
        int t0, k;
        xfer(c, b, a, be, 32'h0);
        t0 = cyc;
        chk("first read", RSP_RETRY, code);
        k = 0;
        while (code === RSP_RETRY && k < 1500) begin
            xfer(c, b, a, be, 32'h0);
            k++;
        end
        t = cyc - t0;
        chk("read code", RSP_DATA, code);
    endtask
    task automatic drain();
        stall <= 1'b0;
        n = 0;
        do begin
            xfer(CMD_MEM_RD, 1'b1, 18'h800, 4'h0, 32'h0);
            n++;
        end while (rdat[FIFO_NE_BIT] !== 1'b0 && n < 300);
        chk("fifo flag", 0, rdat[FIFO_NE_BIT]);
    endtask

    ////////////////////////////////////////////////////////////
    task automatic s_post();
        stall <= 1'b1;
        xfer(CMD_MEM_WR, 1'b0, 18'h10, 4'h0, 32'hbeef_1234);
        chk("wr code", RSP_DONE, code);
        xfer(CMD_MEM_WR_INV, 1'b0, 18'h14, 4'h0, 32'h5a5a_0f0f);
        chk("mwi code", RSP_DONE, code);
        xfer(CMD_MEM_RD, 1'b1, 18'h800, 4'h0, 32'h0);
        chk("fifo flag", 1, rdat[FIFO_NE_BIT]);
        xfer(CMD_MEM_WR, 1'b1, 18'h81c, 4'h0, 32'h0000_00a5);
        xfer(CMD_MEM_RD, 1'b1, 18'h81c, 4'h0, 32'h0);
        chk("ifreg", 32'h0000_00a5, rdat);
        xfer(CMD_MEM_RD, 1'b0, 18'h10, 4'h0, 32'h0);
        chk("busy fifo read", RSP_RETRY, code);
        drain();
        chk("mem 8", 16'h1234, u_core.mem_ff[8]);
        chk("mem 9", 16'hbeef, u_core.mem_ff[9]);
        chk("mem 11", 16'h5a5a, u_core.mem_ff[11]);
    endtask
    // read latency, quiet and contested
    task automatic s_timing();
        rd_poll(CMD_MEM_RD, 1'b0, 18'h10, 4'hc);
        chk("single data", 16'h1234, rdat[15:0]);
        win("single time", t, 8 * P + 5 * C, 10 * P + 6 * C);
        rd_poll(CMD_MEM_RD_LN, 1'b0, 18'h10, 4'h0);
        chk("double data", 32'hbeef_1234, rdat);
        win("double time", t, 13 * P + 11 * C, 16 * P + 14 * C);
        core_busy_i <= 1'b1;
        core_cfg6_i <= 16'h4000;
        rd_poll(CMD_MEM_RD_MUL, 1'b0, 18'h14, 4'h0);
        chk("fast data", 32'h5a5a_0f0f, rdat);
        win("fast time", t, 13 * P + 11 * C, 16 * P + 20 * C);
        core_cfg6_i <= 16'h0000;
        rd_poll(CMD_MEM_RD, 1'b0, 18'h14, 4'hc);
        win("slow time", t, 10 * P + 9 * C, 10 * P + 73 * C);
        core_busy_i <= 1'b0;
    endtask
    task automatic s_regs_half();
        xfer(CMD_MEM_WR, 1'b0, 18'h20, 4'h3, 32'haaaa_5555);
        xfer(CMD_MEM_WR, 1'b1, 18'h08, 4'h0, 32'h1111_2222);
        xfer(CMD_MEM_WR, 1'b1, 18'h0c, 4'h3, 32'h3333_4444);
        drain();
        chk("low half skipped", 16'h0000, u_core.mem_ff[16]);
        chk("high half", 16'haaaa, u_core.mem_ff[17]);
        chk("reg low", 16'h2222, u_core.reg_ff[2]);
        chk("reg upper only", 16'h0000, u_core.reg_ff[3]);
        rd_poll(CMD_MEM_RD, 1'b1, 18'h08, 4'h0);
        chk("reg read", 16'h2222, rdat[15:0]);
    endtask
    task automatic s_abort();
        logic [3:0] bl [4] = '{4'he, 4'hd, 4'hb, 4'h7};
        foreach (bl[i]) begin
            xfer(CMD_MEM_WR, 1'b0, 18'h30, bl[i], 32'hffff_ffff);
            chk("mem abort", RSP_ABORT, code);
            xfer(CMD_MEM_WR_INV, 1'b1, 18'h04, bl[i], 32'hffff_ffff);
            chk("reg abort", RSP_ABORT, code);
        end
        xfer(CMD_MEM_RD, 1'b1, 18'h800, 4'h0, 32'h0);
        chk("nothing stored", 0, rdat[FIFO_NE_BIT]);
    endtask
    // burst into a stalled core until refused
    task automatic s_burst();
        int k;
        stall <= 1'b1;
        for (k = 0; k < 24; k++) begin
            req_i <= {CMD_MEM_WR, 1'b0, 18'(18'h40 + 4 * k), 4'h0, 16'(k + 256), 16'(k)};
            req_valid_i <= 1'b1;
            #1;
            if (req_ready_o !== 1'b1) break;
            @(posedge clk_i);
        end
        req_valid_i <= 1'b0;
        chk("burst taken", 1, k >= 16 && k < 24);
        drain();
        for (int i = 0; i < k; i++) begin
            chk("burst low", 16'(i), u_core.mem_ff[32 + 2 * i]);
            chk("burst high", 16'(i + 256), u_core.mem_ff[33 + 2 * i]);
        end
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        s_post();
        s_timing();
        s_regs_half();
        s_abort();
        s_burst();
        end_sim();
    end
endmodule // pwb_bridge_tb
